//--- cdd_defs.svh
// Register offsets, field positions, reset values and divider limits for the channel divider.
`ifndef CDD_DEFS_SVH
`define CDD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CDD_ADDR_STAGE1 8'h00
`define CDD_ADDR_STAGE2 8'h04
`define CDD_ADDR_CTRL 8'h08
`define CDD_ADDR_STATUS 8'h0c
`define CDD_ADDR_MEAS 8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CDD_STG_HIGH_LSB 0
`define CDD_STG_LOW_LSB 4
`define CDD_STG_BYPASS_BIT 8
`define CDD_CTRL_DCC_DIS_BIT 0
`define CDD_CTRL_VCO_LSB 4
`define CDD_MEAS_HIGH_LSB 16

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define CDD_STAGE_RESET 9'h100
`define CDD_DCC_DIS_RESET 1'h0
`define CDD_VCO_DIV_RESET 3'h0
`define CDD_VCO_DIV_MIN 3'h2
`define CDD_STAGE_EXTRA 6'h02
`define CDD_MEAS_MAX 16'hffff

`endif

//--- cdd_pkg.sv
// Types shared by the channel divider and its cascade stages.
package cdd_pkg;

  // Settings of one divide stage as the stage logic sees them.
  typedef struct packed {
    logic [5:0] total;    // Input rising edges per output period.
    logic [5:0] high;     // Input rising edges spent high.
    logic bypass;         // Pass the input straight through.
    logic stretch;        // Hold high until the next input falling edge.
  } cdd_stage_cfg_type;

  // Software view of one cascade stage.
  typedef struct packed {
    logic bypass;
    logic [3:0] low_cnt;
    logic [3:0] high_cnt;
  } cdd_stage_reg_type;

  typedef enum logic [1:0] {
    CDD_MEAS_IDLE = 2'b00,
    CDD_MEAS_HIGH = 2'b01,
    CDD_MEAS_LOW = 2'b10
  } cdd_meas_state_type;

endpackage

//--- cdd_stage.sv
// One divide stage: counts input rising edges, optional falling-edge stretch.
`timescale 1ns/1ps
`include "cdd_defs.svh"

module cdd_stage (
  input wire logic clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire cdd_pkg::cdd_stage_cfg_type cfg, // Stage settings.
  input wire logic in_level, // Sampled stage input waveform.
  output logic out_level // Divided waveform.
);

  logic in_prev_reg;
  logic [5:0] cnt_reg;
  logic out_reg;
  logic hold_reg;
  logic in_rise;
  logic in_fall;
  logic [5:0] cnt_next;

  assign in_rise = in_level & ~in_prev_reg;
  assign in_fall = ~in_level & in_prev_reg;
  assign cnt_next = cnt_reg + 6'h01;
  assign out_level = out_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      in_prev_reg <= 1'b0;
    else
      in_prev_reg <= in_level;
  end

  // ----------------------------------------------------------------------------
  // Edge counting
  // ----------------------------------------------------------------------------
  // The compare is >= so that a divide ratio shrunk on the fly cannot strand the counter.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= 6'h00;
      out_reg <= 1'b0;
      hold_reg <= 1'b0;
    end
    else if (cfg.bypass)
    begin
      cnt_reg <= 6'h00;
      out_reg <= in_level;
      hold_reg <= 1'b0;
    end
    else if (in_rise)
    begin
      if (cnt_next >= cfg.total)
      begin
        cnt_reg <= 6'h00;
        out_reg <= 1'b1;
        hold_reg <= 1'b0;
      end
      else
      begin
        cnt_reg <= cnt_next;
        if (cnt_next == cfg.high)
        begin
          if (cfg.stretch)
            hold_reg <= 1'b1;
          else
            out_reg <= 1'b0;
        end
      end
    end
    else if (in_fall && hold_reg)
    begin
      out_reg <= 1'b0;
      hold_reg <= 1'b0;
    end
  end

endmodule // cdd_stage

//--- cdd_channel.sv
// Cascaded channel divider with optional VCO divider and duty-cycle correction.
`timescale 1ns/1ps
`include "cdd_defs.svh"

module cdd_channel (
  input wire logic clk, // System clock, 100 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic div_in, // Divider source waveform, sampled on clk.
  input wire logic [7:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  output logic clk_out // Divided channel output.
);

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  cdd_pkg::cdd_stage_reg_type stage1_reg;
  cdd_pkg::cdd_stage_reg_type stage2_reg;
  logic duty_correction_disable_reg;
  logic [2:0] vco_div_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_reg <= `CDD_STAGE_RESET;
      stage2_reg <= `CDD_STAGE_RESET;
      duty_correction_disable_reg <= `CDD_DCC_DIS_RESET;
      vco_div_reg <= `CDD_VCO_DIV_RESET;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `CDD_ADDR_STAGE1: stage1_reg <= reg_wdata[8:0];
        `CDD_ADDR_STAGE2: stage2_reg <= reg_wdata[8:0];
        `CDD_ADDR_CTRL:
        begin
          duty_correction_disable_reg <= reg_wdata[`CDD_CTRL_DCC_DIS_BIT];
          vco_div_reg <= reg_wdata[`CDD_CTRL_VCO_LSB +: 3];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Stage settings
  // ----------------------------------------------------------------------------
  cdd_pkg::cdd_stage_cfg_type stage_cfg [3];
  logic dcc_en;
  logic [5:0] stg1_total;
  logic [5:0] stg2_total;
  logic dcc_cfg_ok;

  assign dcc_en = ~duty_correction_disable_reg;

  // Stored counts are cycles minus one, hence the +1 per field.
  assign stg1_total = {2'b00, stage1_reg.high_cnt} + {2'b00, stage1_reg.low_cnt} +
                      `CDD_STAGE_EXTRA;
  assign stg2_total = {2'b00, stage2_reg.high_cnt} + {2'b00, stage2_reg.low_cnt} +
                      `CDD_STAGE_EXTRA;

  // Index 0 is the VCO divider, a value below two means it is not in the path.
  always_comb
  begin
    stage_cfg[0].bypass = (vco_div_reg < `CDD_VCO_DIV_MIN);
    stage_cfg[0].total = {3'b000, vco_div_reg};
    stage_cfg[0].high = {4'h0, vco_div_reg[2:1]};
    stage_cfg[0].stretch = dcc_en & vco_div_reg[0];
    stage_cfg[1].bypass = stage1_reg.bypass;
    stage_cfg[1].total = stg1_total;
    stage_cfg[1].high = {2'b00, stage1_reg.high_cnt} + 6'h01;
    stage_cfg[1].stretch = dcc_en & stg1_total[0];
    stage_cfg[2].bypass = stage2_reg.bypass;
    stage_cfg[2].total = stg2_total;
    stage_cfg[2].high = {2'b00, stage2_reg.high_cnt} + 6'h01;
    stage_cfg[2].stretch = dcc_en & stg2_total[0];
  end

  // Flags settings for which the corrected duty is not defined.
  always_comb
  begin
    dcc_cfg_ok = 1'b1;
    if (!stage1_reg.bypass && !stg1_total[0] && stage1_reg.low_cnt != stage1_reg.high_cnt)
      dcc_cfg_ok = 1'b0;
    if (!stage1_reg.bypass && stg1_total[0] && stage1_reg.low_cnt != stage1_reg.high_cnt + 4'h1)
      dcc_cfg_ok = 1'b0;
    if (!stage2_reg.bypass && !stg2_total[0] && stage2_reg.low_cnt != stage2_reg.high_cnt)
      dcc_cfg_ok = 1'b0;
    if (!stage2_reg.bypass && stg2_total[0] && stage2_reg.low_cnt != stage2_reg.high_cnt + 4'h1)
      dcc_cfg_ok = 1'b0;
    if (stage1_reg.bypass && !stage2_reg.bypass)
      dcc_cfg_ok = 1'b0;
    if (!stage1_reg.bypass && !stage2_reg.bypass && !stg1_total[0] && stg2_total[0])
      dcc_cfg_ok = 1'b0;
    if (!dcc_en)
      dcc_cfg_ok = 1'b1;
  end

  // ----------------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------------
  // Each stage adds one cycle of latency; duty and ratio are unaffected by it.
  logic [3:0] chain;

  assign chain[0] = div_in;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_stage
      cdd_stage u_stage (
        .clk(clk),
        .rstn(rstn),
        .cfg(stage_cfg[gi]),
        .in_level(chain[gi]),
        .out_level(chain[gi + 1])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      clk_out <= 1'b0;
    else
      clk_out <= chain[3];
  end

  // ----------------------------------------------------------------------------
  // Output period and high-time measurement
  // ----------------------------------------------------------------------------
  // Counts saturate, so very slow outputs read as the ceiling rather than wrapping.
  cdd_pkg::cdd_meas_state_type meas_state_reg;
  logic out_prev_reg;
  logic [15:0] per_cnt_reg;
  logic [15:0] high_cnt_reg;
  logic [15:0] period_reg;
  logic [15:0] high_time_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      out_prev_reg <= 1'b0;
    else
      out_prev_reg <= clk_out;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meas_state_reg <= cdd_pkg::CDD_MEAS_IDLE;
      per_cnt_reg <= 16'h0000;
      high_cnt_reg <= 16'h0000;
      period_reg <= 16'h0000;
      high_time_reg <= 16'h0000;
    end
    else if (clk_out && !out_prev_reg)
    begin
      if (meas_state_reg != cdd_pkg::CDD_MEAS_IDLE)
      begin
        period_reg <= per_cnt_reg;
        high_time_reg <= high_cnt_reg;
      end
      meas_state_reg <= cdd_pkg::CDD_MEAS_HIGH;
      per_cnt_reg <= 16'h0001;
      high_cnt_reg <= 16'h0001;
    end
    else
    begin
      unique case (meas_state_reg)
        cdd_pkg::CDD_MEAS_IDLE: ;
        cdd_pkg::CDD_MEAS_HIGH:
        begin
          if (per_cnt_reg != `CDD_MEAS_MAX)
            per_cnt_reg <= per_cnt_reg + 16'h0001;
          if (!clk_out)
            meas_state_reg <= cdd_pkg::CDD_MEAS_LOW;
          else if (high_cnt_reg != `CDD_MEAS_MAX)
            high_cnt_reg <= high_cnt_reg + 16'h0001;
        end
        cdd_pkg::CDD_MEAS_LOW:
        begin
          if (per_cnt_reg != `CDD_MEAS_MAX)
            per_cnt_reg <= per_cnt_reg + 16'h0001;
        end
        default: meas_state_reg <= cdd_pkg::CDD_MEAS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `CDD_ADDR_STAGE1: reg_rdata <= {23'h000000, stage1_reg};
        `CDD_ADDR_STAGE2: reg_rdata <= {23'h000000, stage2_reg};
        `CDD_ADDR_CTRL: reg_rdata <= {25'h0000000, vco_div_reg, 3'h0, duty_correction_disable_reg};
        `CDD_ADDR_STATUS: reg_rdata <= {30'h00000000, clk_out, dcc_cfg_ok};
        `CDD_ADDR_MEAS: reg_rdata <= {high_time_reg, period_reg};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule // cdd_channel

//--- cdd_channel_props.sv
// Checker for the channel divider register port and output.
`timescale 1ns/1ps
`include "cdd_defs.svh"

module cdd_channel_props (
  input wire logic clk, // Clock.
  input wire logic rstn, // Reset, active low.
  input wire logic div_in, // Source waveform.
  input wire logic [7:0] reg_addr, // Address.
  input wire logic [31:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  input wire logic [31:0] reg_rdata, // Read data.
  input wire logic clk_out // Divided output.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------------
  // Shadow copies of the writable registers
  // ------------------------------------------------------------------
  logic [8:0] s1_reg;
  logic [8:0] s2_reg;
  logic [3:0] ctl_reg;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      s1_reg <= `CDD_STAGE_RESET;
      s2_reg <= `CDD_STAGE_RESET;
      ctl_reg <= 4'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `CDD_ADDR_STAGE1) s1_reg <= reg_wdata[8:0];
      if (reg_addr == `CDD_ADDR_STAGE2) s2_reg <= reg_wdata[8:0];
      if (reg_addr == `CDD_ADDR_CTRL) ctl_reg <= {reg_wdata[6:4], reg_wdata[0]};
    end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_idle_zero;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) |=> reg_rdata == 32'h0;
  endproperty
  property p_stage1;
    reg_rd && reg_addr == `CDD_ADDR_STAGE1 |=> reg_rdata == {23'h0, $past(s1_reg)};
  endproperty
  property p_stage2;
    reg_rd && reg_addr == `CDD_ADDR_STAGE2 |=> reg_rdata == {23'h0, $past(s2_reg)};
  endproperty
  property p_ctrl;
    reg_rd && reg_addr == `CDD_ADDR_CTRL |=> {reg_rdata[6:4], reg_rdata[0]} == $past(ctl_reg);
  endproperty
  property p_status_off;
    reg_rd && reg_addr == `CDD_ADDR_STATUS && ctl_reg[0] |=> reg_rdata[0];
  endproperty
  property p_meas;
    reg_rd && reg_addr == `CDD_ADDR_MEAS |=> reg_rdata[31:16] <= reg_rdata[15:0];
  endproperty
  property p_rst_out;
    $rose(rstn) |-> !clk_out;
  endproperty

  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_stage1: assert property (p_stage1) else $error("first stage readback wrong");
  a_stage2: assert property (p_stage2) else $error("second stage readback wrong");
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  a_status_off: assert property (p_status_off) else $error("status valid low");
  a_meas: assert property (p_meas) else $error("high time above period");
  a_rst_out: assert property (p_rst_out) else $error("output high out of reset");

  c_meas: cover property (reg_rd && reg_addr == `CDD_ADDR_MEAS);
  c_off: cover property (reg_wr && reg_addr == `CDD_ADDR_CTRL && reg_wdata[0]);
  c_stage2: cover property (reg_wr && reg_addr == `CDD_ADDR_STAGE2 && !reg_wdata[8]);
endmodule // cdd_channel_props

bind cdd_channel cdd_channel_props i_cdd_channel_props (.clk(clk), .rstn(rstn),
  .div_in(div_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_out(clk_out));

//--- cdd_channel_test.sv
// Self-checking bench for the cascaded channel divider.
`timescale 1ns/1ps
`include "cdd_defs.svh"

module cdd_channel_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic div_in = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic clk_out;
  logic [31:0] rv;
  int mismatches = 0;
  int tests_run = 0;
  integer seed = 49031;
  int src_per = 4;
  int src_hi = 2;
  int ph = 0;
  int dsel[6] = '{0, 2, 3, 4, 5, 6};
  int rn[2];
  int rm[2];
  int rb[2];
  int mon_per = 0;
  int mon_hi = 0;
  int mon_cnt = 0;
  int mon_hcnt = 0;
  logic mon_prev = 1'b0;

  cdd_channel i_cdd_channel (.clk(clk), .rstn(rstn), .div_in(div_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clk_out(clk_out));

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    ph <= (ph + 1 >= src_per) ? 0 : ph + 1;
    div_in <= (ph < src_hi);
  end

  // Times the output pin itself, so a fault shared by the chain and the on-chip meter still shows.
  always @(posedge clk)
  begin
    mon_prev <= clk_out;
    if (clk_out && !mon_prev)
    begin
      mon_per <= mon_cnt;
      mon_hi <= mon_hcnt;
      mon_cnt <= 1;
      mon_hcnt <= 1;
    end
    else
    begin
      mon_cnt <= mon_cnt + 1;
      if (clk_out)
        mon_hcnt <= mon_hcnt + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Reference: output period and high time in clocks, built stage by stage.
  function automatic void model(input int d, dis, input int n[2], m[2], b[2],
                                output int per, output int hi);
    per = src_per;
    hi = src_hi;
    if (d >= 2)
    begin
      hi = (d / 2) * per + ((!dis && d % 2) ? hi : 0);
      per = d * per;
    end
    for (int k = 0; k < 2; k++)
      if (!b[k])
      begin
        hi = (n[k] + 1) * per + ((!dis && (n[k] + m[k]) % 2) ? hi : 0);
        per = (n[k] + m[k] + 2) * per;
      end
  endfunction

  // Settings whose duty is left open are only checked for period.
  function automatic bit valid(input int dis, input int n[2], m[2], b[2]);
    bit ok = !(b[0] && !b[1]);
    if (!dis)
    begin
      for (int k = 0; k < 2; k++)
        if (!b[k] && m[k] != n[k] + (n[k] + m[k]) % 2) ok = 0;
      if (!b[1] && (n[0] + m[0]) % 2 == 0 && (n[1] + m[1]) % 2) ok = 0;
    end
    return ok;
  endfunction

  task automatic run(input int d, dis, input int n[2], m[2], b[2]);
    int per;
    int hi;
    model(d, dis, n, m, b, per, hi);
    wr(`CDD_ADDR_STAGE1, {23'h0, b[0][0], m[0][3:0], n[0][3:0]});
    wr(`CDD_ADDR_STAGE2, {23'h0, b[1][0], m[1][3:0], n[1][3:0]});
    wr(`CDD_ADDR_CTRL, {25'h0, d[2:0], 3'h0, dis[0]});
    repeat (4 * per + 40) @(posedge clk);
    rd(`CDD_ADDR_MEAS, rv);
    check({16'h0, rv[15:0]}, per);
    check(mon_per, per);
    if (valid(dis, n, m, b))
    begin
      check({16'h0, rv[31:16]}, hi);
      check(mon_hi, hi);
    end
    rd(`CDD_ADDR_STAGE2, rv);
    check(rv, {23'h0, b[1][0], m[1][3:0], n[1][3:0]});
    rd(`CDD_ADDR_STATUS, rv);
    check({31'h0, rv[0]}, {31'h0, valid(dis, n, m, b) | dis[0]});
    $display("test vco=%0d off=%0d done", d, dis);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(`CDD_ADDR_STAGE1, rv);
    check(rv, {23'h0, `CDD_STAGE_RESET});
    rd(`CDD_ADDR_CTRL, rv);
    check(rv, 32'h0);
    rd(8'h20, rv);
    check(rv, 32'h0);
    wr(`CDD_ADDR_MEAS, 32'hffffffff);
    repeat (20) @(posedge clk);
    rd(`CDD_ADDR_MEAS, rv);
    check(rv, 32'h00020004);
    src_hi = 1;
    for (int d = 0; d <= 6; d++)
      for (int dis = 0; dis < 2; dis++)
        if (d != 1) run(d, dis, '{0, 0}, '{0, 0}, '{1, 1});
    run(0, 1, '{3, 0}, '{1, 0}, '{0, 1});
    src_hi = 2;
    run(3, 0, '{1, 0}, '{2, 1}, '{0, 0});
    run(5, 0, '{1, 0}, '{1, 0}, '{0, 1});
    run(3, 1, '{2, 1}, '{0, 2}, '{0, 0});
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(`CDD_ADDR_CTRL, rv);
    check(rv, 32'h0);
    rd(`CDD_ADDR_STAGE2, rv);
    check(rv, {23'h0, `CDD_STAGE_RESET});
    $display("test mid-run reset done");
    for (int t = 0; t < 12; t++)
    begin
      src_hi = 1 + $unsigned($random(seed)) % 3;
      for (int k = 0; k < 2; k++)
      begin
        rn[k] = $unsigned($random(seed)) % 3;
        rm[k] = $unsigned($random(seed)) % 3;
        rb[k] = $random(seed) & 1;
      end
      run(dsel[$unsigned($random(seed)) % 6], $random(seed) & 1, rn, rm, rb);
    end
    stop_test();
  end

  initial
  begin
    #600000;
    mismatches++;
    stop_test();
  end
endmodule // cdd_channel_test
